// ---- verilog/dpc_datapath_config.v ----
`timescale 1ns/10ps
`include "dpc_regs.vh"

// Function
// - Lock bit set blocks forward-channel reload.
// - Lock clear reloads bits 6..0 remotely.
// - Ungated bit passes pixels ignoring data-valid.
// - Ungated disables decryption, blocks packetized audio.
// - Bit 5 selects data-valid polarity.
// - Bit 4 suppresses packetized audio on pixels.
// - Bit 3 overrides four-channel audio enable.
// - Bit 2 one means 18-bit, zero 24-bit.
// - Bit 1 one in-band, zero data-island audio.
// - Bit 0 enables four-channel serial audio.
// - Checksum enable validates one-byte checksum per line.
// - Checksum failure recorded in protection status.
module dpc_datapath_config (
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave port.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Configuration arriving from the remote serializer.
    input wire fwd_cfg_valid,
    input wire [6:0] fwd_cfg_data,
    // Recovered pixel stream.
    input wire [23:0] pix_in_data,
    input wire pix_in_data_valid,
    input wire pix_in_is_audio,
    // Line checksum byte that follows each video line.
    input wire line_chk_valid,
    input wire [7:0] line_chk_byte,
    // Pixel outputs.
    output reg [23:0] pix_out_data,
    output reg pix_out_data_valid,
    output reg pix_out_is_audio,
    // Mode outputs toward the audio and decryption engines.
    output wire decrypt_enable,
    output wire audio_four_ch_enable,
    output wire audio_inband,
    output wire video_18bit
);

    // Datapath control register and its next value.
    reg [7:0] dp_ctrl_q;
    reg [7:0] dp_ctrl_d;
    // Line checksum enable held in the receive mode register.
    reg chk_en_q;
    reg chk_en_d;
    // Sticky checksum failure flag.
    reg chk_fail_q;
    reg chk_fail_d;
    // Running checksum of the current line.
    reg [7:0] line_sum_q;
    reg [7:0] line_sum_d;
    // Captured address phase.
    reg wr_pend_q;
    reg [9:0] wr_addr_q;
    // Address phase decode results.
    wire addr_phase;
    wire rd_take;
    // Data-phase write strobes per register.
    wire wr_ctrl;
    wire wr_mode;
    wire wr_stat;
    // Effective active-high data valid after polarity.
    wire valid_eff;
    // Pixel word gated and masked for the output.
    reg [23:0] pix_sel;
    reg [23:0] pix_sel_d;
    reg pix_valid_d;
    reg pix_audio_d;

    // Decode a byte address against one register; used for reads and writes.
    // One shared compare keeps read and write decoding from ever disagreeing.
    function match;
        input [9:0] addr;
        input [9:0] reg_addr;
        begin
            match = (addr == reg_addr);
        end
    endfunction

    // The slave never stalls and never signals an error.
    // Each register answers in its data phase, so no wait state is ever inserted.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
    // SEQ is accepted too, although the master only issues single transfers.
    assign addr_phase = hsel & htrans[1] & hready;
    assign rd_take = addr_phase & ~hwrite;

    // Write strobes act in the data phase using hwdata.
    assign wr_ctrl = wr_pend_q & match(wr_addr_q, `DPC_ADDR_DATAPATH_CONTROL);
    assign wr_mode = wr_pend_q & match(wr_addr_q, `DPC_ADDR_RECEIVE_MODE_STATE);
    assign wr_stat = wr_pend_q & match(wr_addr_q, `DPC_ADDR_PROTECTION_STATUS);

    // Address phase capture; only word transfers are expected, hsize is not checked.
    // The capture moves only while hready is high, so a stretched data phase keeps its write.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h000;
        end
        else if (hready)
        begin
            wr_pend_q <= addr_phase & hwrite;
            wr_addr_q <= haddr[9:0];
        end
    end

    // Next value of the control register.
    // A local write wins over a remote load in the same cycle, so software is never lost.
    // The lock acts on its stored value, so a write that sets it guards from the next cycle.
    always @*
    begin
        dp_ctrl_d = dp_ctrl_q;
        if (wr_ctrl)
        begin
            dp_ctrl_d = hwdata[7:0];
        end
        else if (fwd_cfg_valid && !dp_ctrl_q[`DPC_BIT_CFG_LOCK])
        begin
            // The lock bit itself is never touched by the remote side.
            dp_ctrl_d = {dp_ctrl_q[`DPC_BIT_CFG_LOCK], fwd_cfg_data};
        end
    end

    // Next value of the checksum enable.
    // Only bit 7 is kept here; the rest of the receive mode register reads as zero.
    always @*
    begin
        chk_en_d = chk_en_q;
        if (wr_mode)
        begin
            chk_en_d = hwdata[`DPC_BIT_LINE_CHECKSUM_EN];
        end
    end

    // Effective data valid: bit 5 set means the incoming signal is active low.
    // Everything downstream sees only the active-high form, whatever the pin polarity.
    assign valid_eff = pix_in_data_valid ^ dp_ctrl_q[`DPC_BIT_VALID_POLARITY];

    // Checksum accumulation and comparison at the end of each line.
    // The sum covers the three bytes of every valid pixel, modulo 256.
    // The checksum cycle itself is not summed, and a mismatch cannot be traced to one pixel.
    always @*
    begin
        line_sum_d = line_sum_q;
        chk_fail_d = chk_fail_q;
        // Write one to clear the sticky failure.
        if (wr_stat && hwdata[`DPC_BIT_CHECKSUM_FAIL])
        begin
            chk_fail_d = 1'b0;
        end
        if (line_chk_valid)
        begin
            // A failure in the clearing cycle still sets, so it is never lost.
            if (chk_en_q && (line_chk_byte != line_sum_q))
            begin
                chk_fail_d = 1'b1;
            end
            line_sum_d = 8'h00;
        end
        else if (valid_eff)
        begin
            line_sum_d = line_sum_q + pix_in_data[23:16] + pix_in_data[15:8] + pix_in_data[7:0];
        end
    end

    // State registers of the configuration and checksum logic.
    // Remote loads and bus writes share this one register, so no shadow copy can drift.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_ctrl_q <= `DPC_RST_DATAPATH_CONTROL;
            chk_en_q <= `DPC_RST_LINE_CHECKSUM_EN;
            chk_fail_q <= `DPC_RST_CHECKSUM_FAIL;
            line_sum_q <= 8'h00;
        end
        else
        begin
            dp_ctrl_q <= dp_ctrl_d;
            chk_en_q <= chk_en_d;
            chk_fail_q <= chk_fail_d;
            line_sum_q <= line_sum_d;
        end
    end

    // Read data is taken from the next values, so a read right after a write
    // returns the new contents even though hrdata is registered.
    // The upper 24 bits always read zero because every register is one byte wide.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (rd_take)
        begin
            if (match(haddr[9:0], `DPC_ADDR_DATAPATH_CONTROL))
            begin
                // Control register, lock bit included.
                hrdata <= {24'h000000, dp_ctrl_d};
            end
            else if (match(haddr[9:0], `DPC_ADDR_RECEIVE_MODE_STATE))
            begin
                // Checksum enable in bit 7, every other bit zero.
                hrdata <= {24'h000000, chk_en_d, 7'h00};
            end
            else if (match(haddr[9:0], `DPC_ADDR_PROTECTION_STATUS))
            begin
                // Sticky checksum failure in bit 0.
                hrdata <= {31'h00000000, chk_fail_d};
            end
            else
            begin
                // Unmapped addresses read as zero.
                hrdata <= 32'h00000000;
            end
        end
    end

    // Pixel selection: gating, audio blocking and colour depth masking.
    // Audio words are never masked, since their bits are not colour samples.
    always @*
    begin
        pix_sel = pix_in_data;
        pix_valid_d = valid_eff;
        pix_audio_d = pix_in_is_audio;
        if (pix_in_is_audio)
        begin
            // Packetized audio is blocked when suppressed or when ungated.
            if (dp_ctrl_q[`DPC_BIT_AUDIO_SUPPRESS] || dp_ctrl_q[`DPC_BIT_PASS_UNGATED])
            begin
                pix_sel = 24'h000000;
                pix_audio_d = 1'b0;
                pix_valid_d = 1'b0;
            end
        end
        else if (dp_ctrl_q[`DPC_BIT_PASS_UNGATED])
        begin
            // Ungated mode passes every non-audio word whatever the data-valid level.
            pix_valid_d = 1'b1;
        end
        else if (!valid_eff)
        begin
            // Normal gating blanks pixels outside the active period.
            pix_sel = 24'h000000;
        end
        pix_sel_d = pix_sel;
        if (dp_ctrl_q[`DPC_BIT_VIDEO_18BIT] && !pix_in_is_audio)
        begin
            // In 18-bit mode the two low bits of each colour carry nothing.
            pix_sel_d = pix_sel & `DPC_MASK_18BIT;
        end
    end

    // Registered pixel outputs.
    // One register stage keeps the outputs clean at the cost of one cycle of latency.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pix_out_data <= 24'h000000;
            pix_out_data_valid <= 1'b0;
            pix_out_is_audio <= 1'b0;
        end
        else
        begin
            pix_out_data <= pix_sel_d;
            pix_out_data_valid <= pix_valid_d;
            pix_out_is_audio <= pix_audio_d;
        end
    end

    // Decryption cannot run when pixels are not framed by data valid.
    // It follows the register directly, so the engine sees a change at once.
    assign decrypt_enable = ~dp_ctrl_q[`DPC_BIT_PASS_UNGATED];

    // Four-channel audio: override one takes bit 0, zero forces it off.
    assign audio_four_ch_enable = dp_ctrl_q[`DPC_BIT_FOUR_CH_OVERRIDE]
        & dp_ctrl_q[`DPC_BIT_FOUR_CH_ENABLE];

    // Audio transport: one selects in-band, zero selects data islands.
    // Kept as a plain level; the audio engine decides when a change may take effect.
    assign audio_inband = dp_ctrl_q[`DPC_BIT_AUDIO_INBAND];

    // Colour depth flag for downstream logic.
    // The pixel mask above already drops the low bits; this flag tells the next stage.
    assign video_18bit = dp_ctrl_q[`DPC_BIT_VIDEO_18BIT];

endmodule // dpc_datapath_config

// ---- verilog/dpc_regs.vh ----
`ifndef DPC_REGS_VH
`define DPC_REGS_VH

// Register indices; byte address is four times the index.
`define DPC_IDX_DATAPATH_CONTROL 8'h22
`define DPC_IDX_RECEIVE_MODE_STATE 8'h23
`define DPC_IDX_PROTECTION_STATUS 8'h30

// Byte addresses on the bus.
`define DPC_ADDR_DATAPATH_CONTROL 10'h088
`define DPC_ADDR_RECEIVE_MODE_STATE 10'h08C
`define DPC_ADDR_PROTECTION_STATUS 10'h0C0

// Datapath control field positions.
`define DPC_BIT_CFG_LOCK 7
`define DPC_BIT_PASS_UNGATED 6
`define DPC_BIT_VALID_POLARITY 5
`define DPC_BIT_AUDIO_SUPPRESS 4
`define DPC_BIT_FOUR_CH_OVERRIDE 3
`define DPC_BIT_VIDEO_18BIT 2
`define DPC_BIT_AUDIO_INBAND 1
`define DPC_BIT_FOUR_CH_ENABLE 0

// Receive mode field position.
`define DPC_BIT_LINE_CHECKSUM_EN 7

// Protection status field position.
`define DPC_BIT_CHECKSUM_FAIL 0

// Reset values.
`define DPC_RST_DATAPATH_CONTROL 8'h00
`define DPC_RST_LINE_CHECKSUM_EN 1'h0
`define DPC_RST_CHECKSUM_FAIL 1'h0

// Mask that drops the two least significant bits of each colour in 18-bit mode.
`define DPC_MASK_18BIT 24'hFCFCFC

`endif

// ---- dv/dpc_fwd_model.sv ----
`timescale 1ns/10ps
// Remote serializer model that pushes configuration words over the forward link.
module dpc_fwd_model (
    input wire hclk,
    output logic fwd_cfg_valid,
    output logic [6:0] fwd_cfg_data
);
    // Idle at time zero with no word offered.
    initial
    begin
        fwd_cfg_valid = 1'b0;
        fwd_cfg_data = 7'h55;
    end
    // One word after a gap; the data lines then show junk so stale values never pass.
    task send(input logic [6:0] d, input int gap);
        repeat (gap) @(posedge hclk);
        fwd_cfg_valid <= 1'b1;
        fwd_cfg_data <= d;
        @(posedge hclk);
        fwd_cfg_valid <= 1'b0;
        fwd_cfg_data <= ~d;
    endtask
endmodule // dpc_fwd_model

// ---- dv/dpc_datapath_config_checker.sv ----
`timescale 1ns/10ps
`include "dpc_regs.vh"
// Port watcher; the lock bit is shadowed from bus writes since it is not a port.
module dpc_datapath_config_checker (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire fwd_cfg_valid,
    input wire [6:0] fwd_cfg_data,
    input wire pix_in_is_audio,
    input wire [23:0] pix_out_data,
    input wire pix_out_data_valid,
    input wire pix_out_is_audio,
    input wire decrypt_enable,
    input wire audio_four_ch_enable,
    input wire audio_inband,
    input wire video_18bit
);
    reg wr_q; // A control write is in its data phase.
    reg lock_q; // Shadow of the lock bit.
    // Track control writes so the lock state is known.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            lock_q <= 1'b0;
        end
        else
        begin
            wr_q <= hsel && htrans[1] && hready && hwrite &&
                haddr[9:0] == `DPC_ADDR_DATAPATH_CONTROL;
            if (wr_q)
                lock_q <= hwdata[7];
        end
    end
    // A bus write beats a remote load, so only clean loads are judged.
    wire load = fwd_cfg_valid && !wr_q && !lock_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    a_fwd_load: assert property (load |=> decrypt_enable == !$past(fwd_cfg_data[6]) &&
        video_18bit == $past(fwd_cfg_data[2]) && audio_inband == $past(fwd_cfg_data[1]))
        else $error("remote load lost");
    a_fwd_locked: assert property (fwd_cfg_valid && lock_q && !wr_q |=>
        $stable(decrypt_enable) && $stable(video_18bit) && $stable(audio_inband))
        else $error("locked register changed");
    a_four_ch: assert property (load |=> audio_four_ch_enable ==
        ($past(fwd_cfg_data[3]) & $past(fwd_cfg_data[0]))) else $error("four channel wrong");
    a_ungated_pass: assert property (!decrypt_enable && !pix_in_is_audio |=>
        pix_out_data_valid) else $error("ungated pixel dropped");
    a_audio_block: assert property (!decrypt_enable && pix_in_is_audio |=>
        !pix_out_is_audio && !pix_out_data_valid) else $error("audio not blocked");
    a_mask_18: assert property (video_18bit && !pix_in_is_audio |=>
        (pix_out_data & 24'h030303) == 24'h0) else $error("low colour bits kept");
    c_load: cover property (load);
    c_locked: cover property (fwd_cfg_valid && lock_q);
    c_block: cover property (!decrypt_enable && pix_in_is_audio);
endmodule // dpc_datapath_config_checker
bind dpc_datapath_config dpc_datapath_config_checker chk_u (.*);

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "dpc_regs.vh"
// Self-checking bench for the datapath configuration block.
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fwd_cfg_valid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize = 3'h2; // Word transfers only.
    logic [6:0] fwd_cfg_data;
    logic [23:0] pix_in_data, pix_out_data;
    logic pix_in_data_valid, pix_in_is_audio, line_chk_valid, pix_out_data_valid;
    logic pix_out_is_audio, decrypt_enable, audio_four_ch_enable, audio_inband, video_18bit;
    logic [7:0] line_chk_byte;
    logic [6:0] pats [4] = '{7'h0F, 7'h01, 7'h08, 7'h74};
    wire hready = hreadyout; // The only slave drives the bus ready.
    int error_cnt, compares, cyc;
    dpc_datapath_config dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .fwd_cfg_valid, .fwd_cfg_data,
        .pix_in_data, .pix_in_data_valid, .pix_in_is_audio, .line_chk_valid, .line_chk_byte,
        .pix_out_data, .pix_out_data_valid, .pix_out_is_audio, .decrypt_enable,
        .audio_four_ch_enable, .audio_inband, .video_18bit);
    dpc_fwd_model fwd_u (.hclk, .fwd_cfg_valid, .fwd_cfg_data);
    // Clock of 50 ns.
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer; the request holds until ready is seen.
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, a};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd = hrdata;
    endtask
    // One pixel for one cycle, then idle so the line sum counts it once.
    task pix(input logic [23:0] d, input logic v, input logic a);
        @(posedge hclk);
        pix_in_data <= d;
        pix_in_data_valid <= v;
        pix_in_is_audio <= a;
        @(posedge hclk);
        pix_in_data <= 24'h0;
        pix_in_data_valid <= 1'b0;
        pix_in_is_audio <= 1'b0;
        #1;
    endtask
    task pc(input logic [7:0] c, input logic [23:0] d, input logic v, a, input logic [25:0] e);
        bus(1'b1, `DPC_ADDR_DATAPATH_CONTROL, {24'h0, c});
        pix(d, v, a);
        chk({pix_out_is_audio, pix_out_data_valid, pix_out_data}, e);
    endtask
    task line(input logic [7:0] b);
        @(posedge hclk);
        line_chk_valid <= 1'b1;
        line_chk_byte <= b;
        @(posedge hclk);
        line_chk_valid <= 1'b0;
    endtask
    task t_regs;
        chk(decrypt_enable, 1'b1);
        bus(1'b0, `DPC_ADDR_DATAPATH_CONTROL, 0);
        chk(rd, 32'h0);
        bus(1'b1, `DPC_ADDR_DATAPATH_CONTROL, 32'hDA);
        bus(1'b0, `DPC_ADDR_DATAPATH_CONTROL, 0);
        chk(rd, 32'hDA);
        chk({decrypt_enable, audio_four_ch_enable, audio_inband, video_18bit}, 4'h2);
        bus(1'b1, 10'h3FC, 32'hFF);
        bus(1'b0, 10'h3FC, 0);
        chk(rd, 32'h0);
    endtask
    task t_fwd;
        bus(1'b1, `DPC_ADDR_DATAPATH_CONTROL, 0);
        foreach (pats[i])
        begin
            fwd_u.send(pats[i], i + 1);
            #1;
            chk({decrypt_enable, audio_four_ch_enable, audio_inband, video_18bit},
                {~pats[i][6], pats[i][3] & pats[i][0], pats[i][1], pats[i][2]});
        end
        bus(1'b1, `DPC_ADDR_DATAPATH_CONTROL, 32'h80);
        fwd_u.send(7'h7F, 1);
        bus(1'b0, `DPC_ADDR_DATAPATH_CONTROL, 0);
        chk(rd, 32'h80);
    endtask
    task t_pix;
        pc(8'h80, 24'h123456, 1'b0, 1'b0, 26'h0);
        pc(8'hA0, 24'h123456, 1'b0, 1'b0, {2'h1, 24'h123456});
        pc(8'hA0, 24'h123456, 1'b1, 1'b0, 26'h0);
        pc(8'hC0, 24'h123456, 1'b0, 1'b0, {2'h1, 24'h123456});
        pc(8'hC0, 24'h654321, 1'b1, 1'b1, 26'h0);
        pc(8'h80, 24'h654321, 1'b1, 1'b1, {2'h3, 24'h654321});
        pc(8'h90, 24'h654321, 1'b1, 1'b1, 26'h0);
        pc(8'h84, 24'hFFFFFF, 1'b1, 1'b0, {2'h1, 24'hFCFCFC});
    endtask
    task t_chk;
        bus(1'b1, `DPC_ADDR_DATAPATH_CONTROL, 32'h80);
        line(8'h00);
        // A bad sum while checking is off must leave the flag clear.
        pix(24'hFFFFFF, 1'b1, 1'b0);
        line(8'h00);
        bus(1'b0, `DPC_ADDR_PROTECTION_STATUS, 0);
        chk(rd, 32'h0);
        bus(1'b1, `DPC_ADDR_RECEIVE_MODE_STATE, 32'h80);
        pix(24'h010203, 1'b1, 1'b0);
        pix(24'h040506, 1'b1, 1'b0);
        line(8'h15);
        bus(1'b0, `DPC_ADDR_PROTECTION_STATUS, 0);
        chk(rd, 32'h0);
        pix(24'hFFFFFF, 1'b1, 1'b0);
        line(8'h00);
        bus(1'b0, `DPC_ADDR_PROTECTION_STATUS, 0);
        chk(rd, 32'h1);
        bus(1'b1, `DPC_ADDR_PROTECTION_STATUS, 32'h1);
        bus(1'b0, `DPC_ADDR_PROTECTION_STATUS, 0);
        chk(rd, 32'h0);
    endtask
    task conclude;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // A hang is cut short well above the expected run length.
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        {pix_in_data, pix_in_data_valid, pix_in_is_audio, line_chk_valid, line_chk_byte} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_fwd();
        t_pix();
        t_chk();
        conclude();
    end
endmodule // tb
